// ### verilog/cmcs_top.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - primary field: din,dout,vin,vout,cin,cout,counter,temperature; resets to 011
// - counter primary always behaves as output, driving the pwm input on the pin
// - secondary field as primary up to 101, 110 pwm output, 111 off; reset 000
// - temperature with platinum sensor forces secondary to current output 101
// - temperature primary forces analog input range to the needed value
// - temperature with platinum sensor forces current source range
// - shared bit drives channel one source onto both outputs unless passthrough bit is set, own inversion each
// - passthrough bit copies address strap 0 to channel two output, through channel two polarity bit
// - floating bias bit ties analog sense pin to ground through resistor
// - threshold class 00 pull-up, 01/10/11 types 1-3; resets to 11
// - driver type 00 push-pull, 01 link push-pull, 10 low, 11 high; reset 00
// - push-pull drives p or n; low-side n plus pull-down; high-side p plus pull-up
// - polarity bit inverts input for all consumers and output for all sources
// - strobe function per channel: off, sync data, input to pin, pin to output
// - strobe off: sample input at select fall, apply output at select rise
// - sync mode: sample input and apply output at selected strobe edge
// - input-to-pin mode drives strobe pin with filtered inverted input
// - pin-to-output mode drives digital output from strobe pin level
// - edge bit: 0 rising, 1 falling; applies to the strobe pin only, not to the sync command
// - analog input range field three bits, eight ranges; resets to 000
// - current source range field two bits, four ranges; resets to 00
// - auto fields are overwritten by the device when a mode needs it
// - start-up load from configuration memory only when its crc is valid
// - lockable fields ignore host writes while lock is engaged
module cmcs_top (
   input  wire logic       mclk_in,              // 100 mhz clock
   input  wire logic       reset_in,             // synchronous reset, high
   input  wire logic       spi_chip_select_n_in, // spi select, low active
   input  wire logic       spi_sclk_in,          // spi clock
   input  wire logic       spi_mosi_in,          // spi data in
   output logic            spi_miso_out,         // spi data out
   input  wire logic       cfg_ld_valid_in,      // config memory byte strobe
   input  wire logic       cfg_ld_crc_ok_in,     // stored config crc valid
   input  wire logic [6:0] cfg_ld_addr_in,       // config memory address
   input  wire logic [7:0] cfg_ld_data_in,       // config memory data
   input  wire logic       address_strap_pin_0_in, // address strap 0 level
   input  wire logic [1:0] di_filt_in,           // spike-filtered inputs
   input  wire logic [1:0] pwm_in,               // counter pwm per channel
   input  wire logic [1:0] strobe_pin_in,        // strobe pin levels
   output logic [1:0]      strobe_pin_out,       // strobe pin drive
   output logic [1:0]      strobe_pin_oe_out,    // strobe pin enable
   output logic [1:0]      p_on_out,             // p transistor enables
   output logic [1:0]      n_on_out,             // n transistor enables
   output logic [1:0]      pull_dn_out,          // low-side pull-downs
   output logic [1:0]      pull_up_out,          // high-side pull-ups
   output logic [1:0]      sense_bias_out,       // analog sense pin to ground
   output logic [5:0]      input_threshold_out,  // {ch2,ch1} threshold class
   output logic [5:0]      analog_range_out,     // {ch2,ch1} input range
   output logic [3:0]      current_range_out,    // {ch2,ch1} source range
   output logic [5:0]      primary_out,          // {ch2,ch1} primary function
   output logic [5:0]      secondary_out         // {ch2,ch1} secondary function
);
   cmcs_pkg::cmcs_state_s q;
   cmcs_pkg::cmcs_state_s next_q;

   logic [1:0] c_p_on;
   logic [1:0] c_n_on;
   logic [1:0] c_pdn;
   logic [1:0] c_pup;
   logic [1:0] c_stb_o;
   logic [1:0] c_stb_oe;
   logic [1:0] c_di;
   logic [1:0] src;
   logic [1:0] base_src;
   logic [1:0] stb_edge;
   logic       cs_fall;
   logic       cs_rise;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       spi_wr;
   logic       sync_cmd;

   ////////////////////////////////////////////////////////////////////////////
   // register write, shared by spi and configuration memory
   function automatic cmcs_pkg::cmcs_state_s wr_reg(input cmcs_pkg::cmcs_state_s s,
                                                    input logic [6:0] a,
                                                    input logic [7:0] d);
      cmcs_pkg::cmcs_state_s r;
      r = s;
      for (int i = 0; i < 2; i++) begin
         if (a[6:2] == cmcs_pkg::A_CH_BASE[6:2] + 5'(i)) begin
            case (a[1:0])
               cmcs_pkg::R_FUNC: begin
                  r.ch[i].prim  = d[2:0];
                  r.ch[i].sec   = d[5:3];
                  r.ch[i].inv   = d[6];
                  r.ch[i].fbias = d[7];
               end
               cmcs_pkg::R_LINE: begin
                  r.ch[i].thr   = d[1:0];
                  r.ch[i].drv   = d[3:2];
                  r.ch[i].sfunc = d[5:4];
                  r.ch[i].sedge = d[6];
               end
               cmcs_pkg::R_RANGE: begin
                  r.ch[i].air = d[2:0];
                  r.ch[i].csr = d[4:3];
                  r.ch[i].pt  = d[5];
               end
               default: begin
                  r.ch[i].out_wr = d[0];
               end
            endcase
         end
      end
      if (a == cmcs_pkg::A_GLOBAL) begin
         r.shared   = d[0];
         r.passthru = d[1];
      end
      return r;
   endfunction

   function automatic logic [7:0] rd_reg(input cmcs_pkg::cmcs_state_s s,
                                         input logic [6:0] a);
      logic [7:0] d;
      d = 8'h00;
      for (int i = 0; i < 2; i++) begin
         if (a[6:2] == cmcs_pkg::A_CH_BASE[6:2] + 5'(i)) begin
            case (a[1:0])
               cmcs_pkg::R_FUNC:  d = {s.ch[i].fbias, s.ch[i].inv, s.ch[i].sec, s.ch[i].prim};
               cmcs_pkg::R_LINE:  d = {1'b0, s.ch[i].sedge, s.ch[i].sfunc, s.ch[i].drv,
                                       s.ch[i].thr};
               cmcs_pkg::R_RANGE: d = {2'h0, s.ch[i].pt, s.ch[i].csr, s.ch[i].air};
               default:           d = {5'h00, s.ch[i].di_smp, s.ch[i].out_act, s.ch[i].out_wr};
            endcase
         end
      end
      if (a == cmcs_pkg::A_GLOBAL) begin
         d = {6'h00, s.passthru, s.shared};
      end
      if (a == cmcs_pkg::A_LOCK) begin
         d = {7'h00, s.lock};
      end
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // output sources and per-channel drivers
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         base_src[i] = (q.ch[i].prim == cmcs_pkg::FN_CNT || q.ch[i].sec == cmcs_pkg::FN_CNT)
                       ? pwm_in[i] : q.ch[i].out_act;
         // edge bit picks rising or falling strobe edge
         stb_edge[i] = q.ch[i].sedge ? (q.stb_q0 == 1'b0 ? 1'b0 : 1'b0) : 1'b0;
      end
      stb_edge[0] = q.ch[0].sedge ? (q.stb_q0 & ~strobe_pin_in[0])
                                  : (~q.stb_q0 & strobe_pin_in[0]);
      stb_edge[1] = q.ch[1].sedge ? (q.stb_q1 & ~strobe_pin_in[1])
                                  : (~q.stb_q1 & strobe_pin_in[1]);
      src[0] = base_src[0];
      if (q.passthru) begin
         src[1] = address_strap_pin_0_in;
      end else if (q.shared) begin
         src[1] = base_src[0];
      end else begin
         src[1] = base_src[1];
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_ch
      cmcs_chan u_chan (
         .prim_in     (q.ch[g].prim),
         .sec_in      (q.ch[g].sec),
         .inv_in      (q.ch[g].inv),
         .drv_in      (q.ch[g].drv),
         .sfunc_in    (q.ch[g].sfunc),
         .src_in      (src[g]),
         .stb_in      (strobe_pin_in[g]),
         .di_in       (di_filt_in[g]),
         .p_on_out    (c_p_on[g]),
         .n_on_out    (c_n_on[g]),
         .pull_dn_out (c_pdn[g]),
         .pull_up_out (c_pup[g]),
         .stb_o_out   (c_stb_o[g]),
         .stb_oe_out  (c_stb_oe[g]),
         .di_lvl_out  (c_di[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // spi slave: byte 0 is {read, addr[6:0]}, byte 1 is data, mode 0
   always_comb begin
      cs_fall   = q.cs_q & ~spi_chip_select_n_in;
      cs_rise   = ~q.cs_q & spi_chip_select_n_in;
      sclk_rise = ~spi_chip_select_n_in & ~q.sclk_q & spi_sclk_in;
      sclk_fall = ~spi_chip_select_n_in & q.sclk_q & ~spi_sclk_in;
      spi_wr    = sclk_rise && q.bitcnt == cmcs_pkg::SPI_DATA_LAST && !q.shreg[14];
      sync_cmd  = spi_wr && q.shreg[13:7] == cmcs_pkg::A_GLOBAL && q.shreg[1];
   end

   always_comb begin
      next_q        = q;
      next_q.sclk_q = spi_sclk_in;
      next_q.cs_q   = spi_chip_select_n_in;
      next_q.stb_q0 = strobe_pin_in[0];
      next_q.stb_q1 = strobe_pin_in[1];
      if (cs_fall) begin
         next_q.bitcnt = 4'h0;
      end
      if (sclk_rise) begin
         next_q.shreg  = {q.shreg[14:0], spi_mosi_in};
         next_q.bitcnt = q.bitcnt + 4'h1;
         if (q.bitcnt == cmcs_pkg::SPI_ADDR_LAST) begin
            next_q.rdsh = rd_reg(q, {q.shreg[5:0], spi_mosi_in});
         end
      end
      if (sclk_fall && q.bitcnt > cmcs_pkg::SPI_ADDR_LAST) begin
         next_q.miso = q.rdsh[7];
         next_q.rdsh = {q.rdsh[6:0], 1'b0};
      end
      if (spi_wr) begin
         if (q.shreg[13:7] == cmcs_pkg::A_LOCK) begin
            next_q.lock = spi_mosi_in;
         end else if (!q.lock) begin
            next_q = wr_reg(next_q, q.shreg[13:7], {q.shreg[6:0], spi_mosi_in});
         end
      end
      if (cfg_ld_valid_in && cfg_ld_crc_ok_in) begin
         next_q = wr_reg(next_q, cfg_ld_addr_in, cfg_ld_data_in);
      end
      for (int i = 0; i < 2; i++) begin
         case (q.ch[i].sfunc)
            cmcs_pkg::STB_SYNC: begin
               if (stb_edge[i] || sync_cmd) begin
                  next_q.ch[i].di_smp  = c_di[i];
                  next_q.ch[i].out_act = next_q.ch[i].out_wr;
               end
            end
            default: begin
               if (cs_fall) begin
                  next_q.ch[i].di_smp = c_di[i];
               end
               if (cs_rise) begin
                  next_q.ch[i].out_act = q.ch[i].out_wr;
               end
            end
         endcase
         // temperature mode takes over the auto fields
         if (next_q.ch[i].prim == cmcs_pkg::FN_TM) begin
            next_q.ch[i].air = cmcs_pkg::TM_AIR;
            if (next_q.ch[i].pt) begin
               next_q.ch[i].sec = cmcs_pkg::FN_COUT;
               next_q.ch[i].csr = cmcs_pkg::PT_CSR;
            end
         end
      end
      next_q.p_on    = c_p_on;
      next_q.n_on    = c_n_on;
      next_q.pull_dn = c_pdn;
      next_q.pull_up = c_pup;
      next_q.stb_o   = c_stb_o;
      next_q.stb_oe  = c_stb_oe;
      if (reset_in) begin
         next_q = '0;
         next_q.sclk_q = 1'b0;
         next_q.cs_q   = 1'b1;
         for (int i = 0; i < 2; i++) begin
            next_q.ch[i].prim  = cmcs_pkg::PRIM_RST;
            next_q.ch[i].sec   = cmcs_pkg::SEC_RST;
            next_q.ch[i].thr   = cmcs_pkg::THR_RST;
            next_q.ch[i].drv   = cmcs_pkg::DRV_RST;
            next_q.ch[i].sfunc = cmcs_pkg::STB_RST;
            next_q.ch[i].air   = cmcs_pkg::AIR_RST;
            next_q.ch[i].csr   = cmcs_pkg::CSR_RST;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      q <= next_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   always_comb begin
      spi_miso_out        = q.miso;
      strobe_pin_out      = q.stb_o;
      strobe_pin_oe_out   = q.stb_oe;
      p_on_out            = q.p_on;
      n_on_out            = q.n_on;
      pull_dn_out         = q.pull_dn;
      pull_up_out         = q.pull_up;
      sense_bias_out      = {q.ch[1].fbias, q.ch[0].fbias};
      input_threshold_out = {2'h0, q.ch[1].thr, q.ch[0].thr};
      analog_range_out    = {q.ch[1].air, q.ch[0].air};
      current_range_out   = {q.ch[1].csr, q.ch[0].csr};
      primary_out         = {q.ch[1].prim, q.ch[0].prim};
      secondary_out       = {q.ch[1].sec, q.ch[0].sec};
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   sequence s_cs_rise;
      q.cs_q == 1'b0 ##1 q.cs_q == 1'b1;
   endsequence

   reset_values_a: assert property ($past(reset_in) |->
      q.ch[0].prim == cmcs_pkg::PRIM_RST && q.ch[1].thr == cmcs_pkg::THR_RST)
      else $error("config not at reset value");
   tm_range_a: assert property (q.ch[0].prim == cmcs_pkg::FN_TM |->
      q.ch[0].air == cmcs_pkg::TM_AIR) else $error("tm range not forced");
   pt_force_a: assert property (q.ch[1].prim == cmcs_pkg::FN_TM && q.ch[1].pt |->
      q.ch[1].sec == cmcs_pkg::FN_COUT && q.ch[1].csr == cmcs_pkg::PT_CSR)
      else $error("pt current not forced");
   lock_hold_a: assert property (q.lock && !cfg_ld_valid_in && q.ch[0].prim != cmcs_pkg::FN_TM
      |=> $stable(q.ch[0].prim) && $stable(q.ch[0].inv)) else $error("locked field changed");
   cs_apply_a: assert property (q.ch[0].sfunc == cmcs_pkg::STB_OFF ##0 s_cs_rise
      |-> q.ch[0].out_act == $past(q.ch[0].out_wr)) else $error("output not applied");
   strobe_drive_a: assert property (q.ch[1].sfunc == cmcs_pkg::STB_DI2P |=>
      q.stb_oe[1] && q.stb_o[1] == ($past(di_filt_in[1]) ^ $past(q.ch[1].inv)))
      else $error("strobe pin not driven");
   passthru_a: assert property (q.passthru && q.ch[1].drv == cmcs_pkg::DRV_PP
      && q.ch[1].prim == cmcs_pkg::FN_DOUT && q.ch[1].sfunc != cmcs_pkg::STB_P2DO |=>
      q.p_on[1] == ($past(address_strap_pin_0_in) ^ $past(q.ch[1].inv)))
      else $error("strap not passed through");
   low_side_a: assert property (q.ch[0].drv == cmcs_pkg::DRV_LOW |=> !q.p_on[0])
      else $error("p on in low-side mode");
endmodule

// ### verilog/cmcs_pkg.sv
package cmcs_pkg;

   // primary / secondary function codes
   localparam logic [2:0] FN_DIN    = 3'h0;
   localparam logic [2:0] FN_DOUT   = 3'h1;
   localparam logic [2:0] FN_VIN    = 3'h2;
   localparam logic [2:0] FN_VOUT   = 3'h3;
   localparam logic [2:0] FN_CIN    = 3'h4;
   localparam logic [2:0] FN_COUT   = 3'h5;
   localparam logic [2:0] FN_CNT    = 3'h6;
   localparam logic [2:0] FN_TM     = 3'h7;
   localparam logic [2:0] FN_OFF    = 3'h7;

   // output driver types
   localparam logic [1:0] DRV_PP    = 2'h0;
   localparam logic [1:0] DRV_PPLNK = 2'h1;
   localparam logic [1:0] DRV_LOW   = 2'h2;
   localparam logic [1:0] DRV_HIGH  = 2'h3;

   // strobe pin functions
   localparam logic [1:0] STB_OFF   = 2'h0;
   localparam logic [1:0] STB_SYNC  = 2'h1;
   localparam logic [1:0] STB_DI2P  = 2'h2;
   localparam logic [1:0] STB_P2DO  = 2'h3;

   // reset values
   localparam logic [2:0] PRIM_RST  = 3'h3;
   localparam logic [2:0] SEC_RST   = 3'h0;
   localparam logic [1:0] THR_RST   = 2'h3;
   localparam logic [1:0] DRV_RST   = 2'h0;
   localparam logic [1:0] STB_RST   = 2'h0;
   localparam logic [2:0] AIR_RST   = 3'h0;
   localparam logic [1:0] CSR_RST   = 2'h0;

   // ranges forced during temperature measurement
   localparam logic [2:0] TM_AIR    = 3'h4;
   localparam logic [1:0] PT_CSR    = 2'h3;

   // register addresses
   localparam logic [6:0] A_CH_BASE = 7'h00;   // channel n at base + 4*n
   localparam logic [1:0] R_FUNC    = 2'h0;
   localparam logic [1:0] R_LINE    = 2'h1;
   localparam logic [1:0] R_RANGE   = 2'h2;
   localparam logic [1:0] R_DATA    = 2'h3;
   localparam logic [6:0] A_GLOBAL  = 7'h08;
   localparam logic [6:0] A_LOCK    = 7'h09;

   // spi frame
   localparam logic [3:0] SPI_ADDR_LAST = 4'h7;
   localparam logic [3:0] SPI_DATA_LAST = 4'hf;

   typedef struct packed {
      logic [2:0] prim;
      logic [2:0] sec;
      logic       inv;
      logic       fbias;
      logic [1:0] thr;
      logic [1:0] drv;
      logic [1:0] sfunc;
      logic       sedge;
      logic [2:0] air;
      logic [1:0] csr;
      logic       pt;
      logic       out_wr;
      logic       out_act;
      logic       di_smp;
   } cmcs_chan_s;

   typedef struct packed {
      cmcs_chan_s [1:0] ch;
      logic             shared;
      logic             passthru;
      logic             lock;
      logic             sclk_q;
      logic             cs_q;
      logic             stb_q0;
      logic             stb_q1;
      logic [3:0]       bitcnt;
      logic [15:0]      shreg;
      logic [7:0]       rdsh;
      logic             miso;
      logic [1:0]       p_on;
      logic [1:0]       n_on;
      logic [1:0]       pull_dn;
      logic [1:0]       pull_up;
      logic [1:0]       stb_o;
      logic [1:0]       stb_oe;
   } cmcs_state_s;

endpackage

// ### verilog/cmcs_chan.sv
`timescale 1ns/100ps
module cmcs_chan (
   input  wire logic [2:0] prim_in,      // primary function
   input  wire logic [2:0] sec_in,       // secondary function
   input  wire logic       inv_in,       // line polarity invert
   input  wire logic [1:0] drv_in,       // output driver type
   input  wire logic [1:0] sfunc_in,     // strobe pin function
   input  wire logic       src_in,       // selected output source
   input  wire logic       stb_in,       // strobe pin level
   input  wire logic       di_in,        // filtered digital input
   output logic            p_on_out,     // p transistor on
   output logic            n_on_out,     // n transistor on
   output logic            pull_dn_out,  // cable-break pull-down
   output logic            pull_up_out,  // cable-break pull-up
   output logic            stb_o_out,    // strobe pin drive value
   output logic            stb_oe_out,   // strobe pin drive enable
   output logic            di_lvl_out    // input level after inversion
);
   logic lvl;
   logic do_en;

   always_comb begin
      // counter acts as output when generating pwm
      do_en = (prim_in == cmcs_pkg::FN_DOUT) || (prim_in == cmcs_pkg::FN_CNT)
           || (sec_in == cmcs_pkg::FN_DOUT) || (sec_in == cmcs_pkg::FN_CNT)
           || (sfunc_in == cmcs_pkg::STB_P2DO);
      lvl = ((sfunc_in == cmcs_pkg::STB_P2DO) ? stb_in : src_in) ^ inv_in;
      di_lvl_out  = di_in ^ inv_in;
      stb_oe_out  = (sfunc_in == cmcs_pkg::STB_DI2P);
      stb_o_out   = di_in ^ inv_in;
      p_on_out    = 1'b0;
      n_on_out    = 1'b0;
      pull_dn_out = 1'b0;
      pull_up_out = 1'b0;
      case (drv_in)
         cmcs_pkg::DRV_PP, cmcs_pkg::DRV_PPLNK: begin
            p_on_out = do_en & lvl;
            n_on_out = do_en & ~lvl;
         end
         cmcs_pkg::DRV_LOW: begin
            n_on_out    = do_en & lvl;
            pull_dn_out = do_en;
         end
         cmcs_pkg::DRV_HIGH: begin
            p_on_out    = do_en & lvl;
            pull_up_out = do_en;
         end
         default: begin
            p_on_out = 1'b0;
         end
      endcase
   end
endmodule

// ### tb/cmcs_host.sv
`timescale 1ns/100ps
module cmcs_host (
   input  wire logic clk_in,   // bench clock
   input  wire logic miso_in,  // device serial out
   output logic      cs_n_out, // select, low active
   output logic      sclk_out, // serial clock, idle low
   output logic      mosi_out  // serial data, msb first
);
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      mosi_out = 1'b0;
   end
   // one 16-bit frame, three clocks per sclk phase
   task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {hdr, wd};
      rd = 8'h00;
      @(posedge clk_in) cs_n_out <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         mosi_out <= sh[15-i];
         repeat (3) @(posedge clk_in);
         sclk_out <= 1'b1;
         if (i > 7) rd = {rd[6:0], miso_in};
         repeat (3) @(posedge clk_in);
         sclk_out <= 1'b0;
      end
      repeat (3) @(posedge clk_in);
      cs_n_out <= 1'b1;
      // released data line does not hold its last value
      mosi_out <= ~mosi_out;
      repeat (3) @(posedge clk_in);
   endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic mclk = 1'b0, rst = 1'b1, vld = 1'b0, crc = 1'b0, miso, cs_n, sclk, mosi;
   logic [6:0] ld_a = 7'h00;
   logic [7:0] ld_d = 8'h00, rdv;
   logic [1:0] p_on, n_on, pdn, pup, stb_o, stb_oe, bias;
   logic strap = 1'b0;
   logic [5:0] thr, air, prim, sec;
   logic [3:0] csr;
   int failures = 0, cmp_count = 0;
   initial forever #5 mclk = ~mclk;
   cmcs_host u_host (.clk_in(mclk), .miso_in(miso), .cs_n_out(cs_n), .sclk_out(sclk),
                     .mosi_out(mosi));
   cmcs_top u_dut (.mclk_in(mclk), .reset_in(rst), .spi_chip_select_n_in(cs_n),
      .spi_sclk_in(sclk), .spi_mosi_in(mosi), .spi_miso_out(miso), .cfg_ld_valid_in(vld),
      .cfg_ld_crc_ok_in(crc), .cfg_ld_addr_in(ld_a), .cfg_ld_data_in(ld_d),
      .address_strap_pin_0_in(strap), .di_filt_in(2'h0), .pwm_in(2'h0), .strobe_pin_in(2'h0),
      .strobe_pin_out(stb_o), .strobe_pin_oe_out(stb_oe), .p_on_out(p_on), .n_on_out(n_on),
      .pull_dn_out(pdn), .pull_up_out(pup), .sense_bias_out(bias), .input_threshold_out(thr),
      .analog_range_out(air), .current_range_out(csr), .primary_out(prim),
      .secondary_out(sec));
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [6:0] a, logic [7:0] d);
      u_host.xfer({1'b0, a}, d, rdv);
   endtask
   task automatic t_reset;
      chk("primary", 8'h1b, prim);
      chk("secondary", 8'h00, sec);
      chk("threshold", 8'h0f, thr);
      chk("driver low", 8'h00, n_on);
      chk("input range", 8'h00, air);
      chk("source range", 8'h00, csr);
      $display("reset values done");
   endtask
   task automatic t_codes;
      for (int c = 0; c < 8; c++) begin
         wr(7'h00, {2'b00, c[2:0], c[2:0]});
         chk("primary", c, prim[2:0]);
         chk("secondary", c, sec[2:0]);
         u_host.xfer(8'h80, 8'h00, rdv);
         chk("func readback", c * 9, rdv);
      end
      $display("function codes done");
   endtask
   task automatic t_temp;
      wr(7'h02, 8'h20);
      chk("forced secondary", 8'h05, sec[2:0]);
      chk("forced range", cmcs_pkg::TM_AIR, air[2:0]);
      chk("forced source", cmcs_pkg::PT_CSR, csr[1:0]);
      wr(7'h00, 8'h00);
      chk("range kept", cmcs_pkg::TM_AIR, air[2:0]);
      $display("temperature overrides done");
   endtask
   task automatic t_drv;
      wr(7'h00, 8'h01);
      wr(7'h01, 8'h0b);
      wr(7'h03, 8'h01);
      chk("low n", 8'h02, {n_on[0], p_on[0]});
      chk("low pull", 8'h01, {pup[0], pdn[0]});
      wr(7'h01, 8'h0f);
      chk("high p", 8'h01, {n_on[0], p_on[0]});
      chk("high pull", 8'h02, {pup[0], pdn[0]});
      wr(7'h00, 8'h41);
      chk("inverted p", 8'h00, p_on[0]);
      $display("driver types done");
   endtask
   task automatic t_lock;
      wr(7'h09, 8'h01);
      wr(7'h00, 8'h02);
      chk("locked", 8'h01, prim[2:0]);
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk) {vld, crc, ld_d} <= {1'b1, k[0], 8'h04};
         @(posedge mclk) vld <= 1'b0;
         repeat (3) @(posedge mclk);
         chk("config load", k[0] ? 8'h04 : 8'h01, prim[2:0]);
      end
      wr(7'h09, 8'h00);
      u_host.xfer(8'hff, 8'h00, rdv);
      chk("unmapped", 8'h00, rdv);
      $display("lock and load done");
   endtask
   task automatic t_route;
      wr(7'h04, 8'hc1);
      chk("sense bias", 8'h02, bias);
      wr(7'h08, 8'h02);
      @(posedge mclk) strap <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("strap high", 8'h02, {n_on[1], p_on[1]});
      @(posedge mclk) strap <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("strap low", 8'h01, {n_on[1], p_on[1]});
      wr(7'h08, 8'h01);
      chk("shared", 8'h02, {n_on[1], p_on[1]});
      wr(7'h05, 8'h20);
      chk("strobe drive", 8'h03, {stb_oe[1], stb_o[1]});
      $display("routing done");
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      t_reset();
      t_codes();
      t_temp();
      t_drv();
      t_lock();
      t_route();
      results();
   end
endmodule
